// ===== rtl/ssi_defs.svh
// Offsets, field positions, reset values and timing counts of the serial encoder receiver
`ifndef SSI_DEFS_SVH
`define SSI_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SSI_OFS_CTRL      8'h00
`define SSI_OFS_CONFIG    8'h04
`define SSI_OFS_PATTERN   8'h08
`define SSI_OFS_POSITION  8'h0C
`define SSI_OFS_FRAME     8'h10
`define SSI_OFS_IRQ_STAT  8'h14
`define SSI_OFS_IRQ_CLR   8'h18
`define SSI_OFS_IRQ_EN    8'h1C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SSI_CTRL_MODE_BIT    0
`define SSI_CFG_NB_LSB       0
`define SSI_CFG_RATE_LSB     8
`define SSI_CFG_PAUSE_LSB    12
`define SSI_CFG_PASSIVE_BIT  16
`define SSI_CFG_GRAY_BIT     17
`define SSI_CFG_NS_LSB       24
`define SSI_FRM_STOP_BIT     8
`define SSI_FRM_PAR_BIT      9
`define SSI_IRQ_FRAME_BIT    0
`define SSI_IRQ_STOP_BIT     1
`define SSI_IRQ_PAR_BIT      2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SSI_CTRL_RST     1'b0
`define SSI_CFG_RST      32'h0000_0218
`define SSI_PATTERN_RST  16'h0000
`define SSI_SYNC_RST     3'b011
`define SSI_STOP_LEVEL   1'b0

// ----------------------------------------
// Timing: clock 25 MHz, rates in kHz, pauses in ns
// ----------------------------------------
`define SSI_SYS_CLK_KHZ  25000
`define SSI_SYS_CLK_NS   40
`define SSI_RATE_KHZ_0   25000
`define SSI_RATE_KHZ_1   12500
`define SSI_RATE_KHZ_2   5000
`define SSI_RATE_KHZ_3   2500
`define SSI_RATE_KHZ_4   1250
`define SSI_RATE_KHZ_5   500
`define SSI_RATE_KHZ_6   250
`define SSI_RATE_KHZ_7   125
`define SSI_PERIOD_CYC(khz)  (`SSI_SYS_CLK_KHZ / (khz))
`define SSI_PERIOD_MIN   2
`define SSI_PAUSE_NS_1   5000
`define SSI_PAUSE_NS_2   10000
`define SSI_PAUSE_NS_3   20000
`define SSI_PAUSE_NS_4   30000
`define SSI_PAUSE_NS_5   50000
`define SSI_PAUSE_NS_6   100000
`define SSI_PAUSE_NS_7   500000
`define SSI_PAUSE_CYC(ns)  (((ns) + `SSI_SYS_CLK_NS - 1) / `SSI_SYS_CLK_NS)
`define SSI_IDLE_NS      20000

`endif

// ===== rtl/ssi_pkg.sv
// Types shared by the serial encoder receiver files
package ssi_pkg;

    // ----------------------------------------
    // Status-bit pattern codes
    // ----------------------------------------
    typedef enum logic [1:0] {STB_PLAIN, STB_STOP, STB_EVEN, STB_ODD} stb_code_t;

    // ----------------------------------------
    // Frame sequencing states
    // ----------------------------------------
    typedef enum {ST_IDLE, ST_FRAME, ST_PAUSE} frame_state_t;

    // ----------------------------------------
    // Decoded configuration
    // ----------------------------------------
    typedef struct packed {
        logic [5:0] data_bit_count;
        logic [2:0] rate;
        logic [2:0] pause;
        logic       passive;
        logic       gray;
        logic [2:0] stb_count_m1;
    } ssi_cfg_t;

    // ----------------------------------------
    // Result of one received frame
    // ----------------------------------------
    typedef struct packed {
        logic [31:0] position;
        logic [7:0]  status;
        logic        stop_err;
        logic        parity_err;
    } frame_result_t;

endpackage : ssi_pkg

// ===== rtl/ssi_clkgen.sv
// Transfer clock divider for active mode
`timescale 1ns/1ps
module ssi_clkgen (
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  wire logic       run,
    input  wire logic [7:0] period,
    output logic            clk_out,
    output logic            rise
);
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic       clk_r;
    logic       clk_nxt;
    logic [7:0] half;

    // ----------------------------------------
    // Divider: low for the first half, high after
    // ----------------------------------------
    always_comb begin
        half = period >> 1;
        if (!run) begin
            cnt_nxt = 8'h00;
            clk_nxt = 1'b1;              // Idles high between frames
        end else begin
            cnt_nxt = (cnt_r == period - 8'h01) ? 8'h00 : cnt_r + 8'h01;
            clk_nxt = (cnt_r >= half);
        end
    end

    // Registers only
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cnt_r <= 8'h00;
            clk_r <= 1'b1;
        end else begin
            cnt_r <= cnt_nxt;
            clk_r <= clk_nxt;
        end
    end

    assign clk_out = clk_r;
    assign rise    = run & ~clk_r & clk_nxt;

endmodule : ssi_clkgen

// ===== rtl/ssi_encoder_receiver.sv
// Synchronous-serial absolute encoder receiver with APB registers
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
`include "ssi_defs.svh"
module ssi_encoder_receiver #(
    parameter logic [13:0] PAUSE_500US_CYC = 14'(`SSI_PAUSE_CYC(`SSI_PAUSE_NS_7))
) (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        board_present,
    input  wire logic        ssi_clk_i,
    output logic             ssi_clk_o,
    output logic             ssi_clk_oe,
    input  wire logic        ssi_data_i,
    output logic             irq
);
    localparam logic [9:0] IDLE_CYC = 10'(`SSI_PAUSE_CYC(`SSI_IDLE_NS));

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    function automatic logic reg_mapped(input logic [7:0] a);
        reg_mapped = (a[1:0] == 2'b00) && (a <= `SSI_OFS_IRQ_EN);
    endfunction : reg_mapped

    function automatic logic [7:0] rate_period(input logic [2:0] sel);
        logic [7:0] p;
        unique case (sel)
            3'd0: p = 8'(`SSI_PERIOD_CYC(`SSI_RATE_KHZ_0));
            3'd1: p = 8'(`SSI_PERIOD_CYC(`SSI_RATE_KHZ_1));
            3'd2: p = 8'(`SSI_PERIOD_CYC(`SSI_RATE_KHZ_2));
            3'd3: p = 8'(`SSI_PERIOD_CYC(`SSI_RATE_KHZ_3));
            3'd4: p = 8'(`SSI_PERIOD_CYC(`SSI_RATE_KHZ_4));
            3'd5: p = 8'(`SSI_PERIOD_CYC(`SSI_RATE_KHZ_5));
            3'd6: p = 8'(`SSI_PERIOD_CYC(`SSI_RATE_KHZ_6));
            3'd7: p = 8'(`SSI_PERIOD_CYC(`SSI_RATE_KHZ_7));
        endcase
        // A flop-driven clock cannot toggle faster than half the system clock
        rate_period = (p < 8'(`SSI_PERIOD_MIN)) ? 8'(`SSI_PERIOD_MIN) : p;
    endfunction : rate_period

    function automatic logic [13:0] pause_cycles(input logic [2:0] sel);
        unique case (sel)
            3'd0: pause_cycles = 14'h0000;
            3'd1: pause_cycles = 14'(`SSI_PAUSE_CYC(`SSI_PAUSE_NS_1));
            3'd2: pause_cycles = 14'(`SSI_PAUSE_CYC(`SSI_PAUSE_NS_2));
            3'd3: pause_cycles = 14'(`SSI_PAUSE_CYC(`SSI_PAUSE_NS_3));
            3'd4: pause_cycles = 14'(`SSI_PAUSE_CYC(`SSI_PAUSE_NS_4));
            3'd5: pause_cycles = 14'(`SSI_PAUSE_CYC(`SSI_PAUSE_NS_5));
            3'd6: pause_cycles = 14'(`SSI_PAUSE_CYC(`SSI_PAUSE_NS_6));
            3'd7: pause_cycles = PAUSE_500US_CYC;
        endcase
    endfunction : pause_cycles

    function automatic logic [31:0] gray_to_bin(input logic [31:0] g);
        logic [31:0] b;
        b[31] = g[31];
        for (int i = 30; i >= 0; i--) begin
            b[i] = b[i + 1] ^ g[i];
        end
        gray_to_bin = b;
    endfunction : gray_to_bin

    // ----------------------------------------
    // Pin synchronisers: board, data, clock
    // ----------------------------------------
    logic [2:0] s1_r, s2_r, s3_r, filt_r, filt_nxt;
    logic       clk_prev_r;

    // A change counts once the last two stages agree
    always_comb begin
        filt_nxt = filt_r;
        for (int i = 0; i < 3; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                filt_nxt[i] = s3_r[i];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            s1_r       <= `SSI_SYNC_RST;
            s2_r       <= `SSI_SYNC_RST;
            s3_r       <= `SSI_SYNC_RST;
            filt_r     <= `SSI_SYNC_RST;
            clk_prev_r <= 1'b1;
        end else begin
            s1_r       <= {board_present, ssi_data_i, ssi_clk_i};
            s2_r       <= s1_r;
            s3_r       <= s2_r;
            filt_r     <= filt_nxt;
            clk_prev_r <= filt_r[0];
        end
    end

    // ----------------------------------------
    // APB slave and register file
    // ----------------------------------------
    logic        ctrl_r, ctrl_nxt;
    logic [31:0] cfg_r, cfg_nxt;
    logic [15:0] pat_r, pat_nxt;
    logic [2:0]  irq_en_r, irq_en_nxt;
    logic [2:0]  irq_stat_r, irq_stat_nxt, irq_set, irq_clr;
    logic        irq_r, irq_nxt;
    logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic [31:0] prdata_r, prdata_nxt, rd_mux;
    logic        wr_done;
    ssi_pkg::frame_result_t res_r, res_nxt;

    // Read mux and register updates; access ends on the second access cycle
    always_comb begin
        pready_nxt = psel & penable & ~pready_r;
        wr_done    = psel & penable & pready_r & pwrite;
        unique case (paddr)
            `SSI_OFS_CTRL:     rd_mux = {31'h0000_0000, ctrl_r};
            `SSI_OFS_CONFIG:   rd_mux = cfg_r;
            `SSI_OFS_PATTERN:  rd_mux = {16'h0000, pat_r};
            `SSI_OFS_POSITION: rd_mux = res_r.position;
            `SSI_OFS_FRAME:    rd_mux = {22'h00_0000, res_r.parity_err,
                                         res_r.stop_err, res_r.status};
            `SSI_OFS_IRQ_STAT: rd_mux = {29'h0000_0000, irq_stat_r};
            `SSI_OFS_IRQ_EN:   rd_mux = {29'h0000_0000, irq_en_r};
            default:           rd_mux = 32'h0000_0000;
        endcase
        prdata_nxt  = pready_nxt ? rd_mux : 32'h0000_0000;
        pslverr_nxt = pready_nxt & ~reg_mapped(paddr);
        ctrl_nxt    = ctrl_r;
        cfg_nxt     = cfg_r;
        pat_nxt     = pat_r;
        irq_en_nxt  = irq_en_r;
        irq_clr     = 3'b000;
        if (wr_done) begin
            unique case (paddr)
                `SSI_OFS_CTRL:    ctrl_nxt   = pwdata[`SSI_CTRL_MODE_BIT];
                `SSI_OFS_CONFIG:  cfg_nxt    = pwdata;
                `SSI_OFS_PATTERN: pat_nxt    = pwdata[15:0];
                `SSI_OFS_IRQ_CLR: irq_clr    = pwdata[2:0];
                `SSI_OFS_IRQ_EN:  irq_en_nxt = pwdata[2:0];
                default:          ctrl_nxt   = ctrl_r;
            endcase
        end
        // Hardware set wins over a clear in the same cycle
        irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;
        irq_nxt      = |(irq_stat_r & irq_en_r);
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ctrl_r     <= `SSI_CTRL_RST;
            cfg_r      <= `SSI_CFG_RST;
            pat_r      <= `SSI_PATTERN_RST;
            irq_en_r   <= 3'b000;
            irq_stat_r <= 3'b000;
            irq_r      <= 1'b0;
            pready_r   <= 1'b0;
            pslverr_r  <= 1'b0;
            prdata_r   <= 32'h0000_0000;
        end else begin
            ctrl_r     <= ctrl_nxt;
            cfg_r      <= cfg_nxt;
            pat_r      <= pat_nxt;
            irq_en_r   <= irq_en_nxt;
            irq_stat_r <= irq_stat_nxt;
            irq_r      <= irq_nxt;
            pready_r   <= pready_nxt;
            pslverr_r  <= pslverr_nxt;
            prdata_r   <= prdata_nxt;
        end
    end

    // ----------------------------------------
    // Configuration decode
    // ----------------------------------------
    ssi_pkg::ssi_cfg_t cfg;
    logic [5:0]  nb_eff;
    logic [3:0]  ns;
    logic [6:0]  total;
    logic        enable;

    always_comb begin
        cfg.data_bit_count = cfg_r[`SSI_CFG_NB_LSB +: 6];
        cfg.rate           = cfg_r[`SSI_CFG_RATE_LSB +: 3];
        cfg.pause          = cfg_r[`SSI_CFG_PAUSE_LSB +: 3];
        cfg.passive        = cfg_r[`SSI_CFG_PASSIVE_BIT];
        cfg.gray           = cfg_r[`SSI_CFG_GRAY_BIT];
        cfg.stb_count_m1   = cfg_r[`SSI_CFG_NS_LSB +: 3];
        // Out-of-range counts clamp to 1..32 data bits
        if (cfg.data_bit_count == 6'd0) begin
            nb_eff = 6'd1;
        end else if (cfg.data_bit_count > 6'd32) begin
            nb_eff = 6'd32;
        end else begin
            nb_eff = cfg.data_bit_count;
        end
        ns     = {1'b0, cfg.stb_count_m1} + 4'd1;
        total  = {1'b0, nb_eff} + {3'b000, ns};
        enable = ctrl_r & filt_r[2];
    end

    // ----------------------------------------
    // Transfer clock generator
    // ----------------------------------------
    ssi_pkg::frame_state_t state_r, state_nxt;
    logic gen_run, gen_clk, gen_rise, oe_r, oe_nxt;

    assign gen_run = (state_r == ssi_pkg::ST_FRAME) & ~cfg.passive & enable;

    ssi_clkgen u_clkgen (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .run     (gen_run),
        .period  (rate_period(cfg.rate)),
        .clk_out (gen_clk),
        .rise    (gen_rise)
    );

    // ----------------------------------------
    // Frame sequencer and shift register
    // ----------------------------------------
    logic [6:0]  bitcnt_r, bitcnt_nxt;
    logic [39:0] sr_r, sr_nxt;
    logic [13:0] pause_r, pause_nxt;
    logic [9:0]  idle_r, idle_nxt;
    logic        sample, finish;

    always_comb begin
        // Passive mode follows the other master's rising edges
        sample     = cfg.passive ? (filt_r[0] & ~clk_prev_r) : gen_rise;
        state_nxt  = state_r;
        bitcnt_nxt = bitcnt_r;
        sr_nxt     = sr_r;
        pause_nxt  = pause_r;
        idle_nxt   = 10'd0;
        finish     = 1'b0;
        oe_nxt     = enable & ~cfg.passive;
        if (!enable) begin
            state_nxt  = ssi_pkg::ST_IDLE;
            bitcnt_nxt = 7'd0;
        end else begin
            unique case (state_r)
                ssi_pkg::ST_IDLE: begin
                    state_nxt  = ssi_pkg::ST_FRAME;
                    bitcnt_nxt = 7'd0;
                end
                ssi_pkg::ST_FRAME: begin
                    if (sample) begin
                        sr_nxt = {sr_r[38:0], filt_r[1]};
                        if (bitcnt_r == total - 7'd1) begin
                            finish     = 1'b1;
                            bitcnt_nxt = 7'd0;
                            if (!cfg.passive) begin
                                state_nxt = ssi_pkg::ST_PAUSE;
                                pause_nxt = pause_cycles(cfg.pause);
                            end
                        end else begin
                            bitcnt_nxt = bitcnt_r + 7'd1;
                        end
                    end
                    // Long idle high clock realigns a passive receiver
                    if (cfg.passive && filt_r[0]) begin
                        idle_nxt = (idle_r == IDLE_CYC) ? idle_r : idle_r + 10'd1;
                        if (idle_r == IDLE_CYC - 10'd1) begin
                            bitcnt_nxt = 7'd0;
                        end
                    end
                end
                ssi_pkg::ST_PAUSE: begin
                    if (pause_r == 14'h0000) begin
                        state_nxt = ssi_pkg::ST_FRAME;
                    end else begin
                        pause_nxt = pause_r - 14'h0001;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_r  <= ssi_pkg::ST_IDLE;
            bitcnt_r <= 7'd0;
            sr_r     <= 40'h00_0000_0000;
            pause_r  <= 14'h0000;
            idle_r   <= 10'd0;
            oe_r     <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            bitcnt_r <= bitcnt_nxt;
            sr_r     <= sr_nxt;
            pause_r  <= pause_nxt;
            idle_r   <= idle_nxt;
            oe_r     <= oe_nxt;
        end
    end

    // ----------------------------------------
    // Frame evaluation: data, coding, checks
    // ----------------------------------------
    logic [39:0] shifted;
    logic [31:0] data_raw;
    logic        par_seen;
    logic [5:0]  idx;
    logic        sbit;

    always_comb begin
        shifted   = sr_nxt >> ns;
        data_raw  = shifted[31:0] & (32'hFFFF_FFFF >> (6'd32 - nb_eff));
        res_nxt   = res_r;
        irq_set   = 3'b000;
        par_seen  = 1'b0;
        idx       = 6'd0;
        sbit      = 1'b0;
        if (finish) begin
            res_nxt.position   = cfg.gray ? gray_to_bin(data_raw) : data_raw;
            res_nxt.status     = sr_nxt[7:0] & (8'hFF >> (4'd8 - ns));
            res_nxt.stop_err   = 1'b0;
            res_nxt.parity_err = 1'b0;
            for (int j = 0; j < 8; j++) begin
                idx  = {2'b00, ns} - 6'(j) - 6'd1;
                sbit = sr_nxt[idx];
                if (6'(j) < {2'b00, ns}) begin
                    // Only the last status bit is checked as a stop bit, and only if its pattern code is STB_STOP
                    if (6'(j) == {2'b00, ns} - 6'd1 &&
                        pat_r[2*j +: 2] == ssi_pkg::STB_STOP) begin
                        res_nxt.stop_err = (sbit != `SSI_STOP_LEVEL);
                    end
                    if (!par_seen && (pat_r[2*j +: 2] == ssi_pkg::STB_EVEN ||
                                      pat_r[2*j +: 2] == ssi_pkg::STB_ODD)) begin
                        par_seen = 1'b1;
                        res_nxt.parity_err = ((^data_raw) ^ sbit) !=
                            (pat_r[2*j +: 2] == ssi_pkg::STB_ODD);
                    end
                end
            end
            irq_set[`SSI_IRQ_FRAME_BIT] = 1'b1;
            irq_set[`SSI_IRQ_STOP_BIT]  = res_nxt.stop_err;
            irq_set[`SSI_IRQ_PAR_BIT]   = res_nxt.parity_err;
        end
    end

    // Holds the last frame until the next one completes
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            res_r <= '0;
        end else begin
            res_r <= res_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign prdata     = prdata_r;
    assign pready     = pready_r;
    assign pslverr    = pslverr_r;
    assign ssi_clk_o  = gen_clk;
    assign ssi_clk_oe = oe_r;
    assign irq        = irq_r;

endmodule : ssi_encoder_receiver

// ===== tb/ssi_encoder_model.sv
// Behavioural absolute encoder for the serial receiver bench
`timescale 1ns/1ps
module ssi_encoder_model (
    input  wire logic        line_clk,
    input  wire logic [39:0] word,
    input  wire logic [5:0]  total,
    output logic             data
);
    logic [39:0] sh;
    int          cnt = 0;

    initial data = 1'b1;

    // New bit on each falling edge, data MSB first, then status
    always @(negedge line_clk) begin
        if (cnt == 0) begin
            sh = word;
            cnt = total;
        end
        cnt = cnt - 1;
        data <= sh[cnt];
    end

    // Frame over: hold time spent, so the line stops showing the last bit
    always @(posedge line_clk)
        if (cnt == 0)
            data <= #200 ~data;
endmodule : ssi_encoder_model

// ===== tb/ssi_encoder_receiver_properties.sv
// Port-level assertions for the serial encoder receiver
`timescale 1ns/1ps
module ssi_rx_checker (
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        board_present,
    input wire logic        ssi_clk_o,
    input wire logic        ssi_clk_oe,
    input wire logic        irq
);
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    apb_wait_a: assert property (psel && !penable |-> ##2 pready)
        else $error("pready not two cycles after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata not zero outside answer");
    unmapped_err_a: assert property (psel && !penable && paddr > 8'h1C |-> ##2 pslverr)
        else $error("no error on unmapped address");
    no_board_a: assert property (!board_present [*8] |-> !ssi_clk_oe)
        else $error("clock driven without board");
    start_fall_a: assert property ($rose(ssi_clk_oe) |-> ##[0:4] !ssi_clk_o)
        else $error("clock did not fall at frame start");
    low_bound_a: assert property ($fell(ssi_clk_o) |-> ##[1:100] ssi_clk_o)
        else $error("clock low phase too long");
    irq_clear_a: assert property (pready && pwrite && paddr == 8'h18 && &pwdata[2:0]
        |-> ##2 !irq)
        else $error("irq stayed after clear");
endmodule : ssi_rx_checker

bind ssi_encoder_receiver ssi_rx_checker i_chk (
    .sys_clk(sys_clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .board_present(board_present), .ssi_clk_o(ssi_clk_o),
    .ssi_clk_oe(ssi_clk_oe), .irq(irq)
);

// ===== tb/ssi_encoder_receiver_tb_top.sv
// Self-checking bench for the serial encoder receiver
`timescale 1ns/1ps
`include "ssi_defs.svh"
module ssi_encoder_receiver_tb_top;
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        board_present = 1'b0;
    logic        link_clk = 1'b1;
    logic        ssi_clk_o;
    logic        ssi_clk_oe;
    logic        ssi_data_i;
    logic        irq;
    logic [39:0] word = 40'h0;
    logic [31:0] rd;
    logic        err;
    logic [11:0] val;
    int          bad_count = 0;
    int          total_checks = 0;
    int          cyc = 0;
    wire         line_clk = ssi_clk_oe ? ssi_clk_o : link_clk;

    ssi_encoder_receiver #(.PAUSE_500US_CYC(14'd50)) i_dut (
        .sys_clk(sys_clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .board_present(board_present), .ssi_clk_i(line_clk),
        .ssi_clk_o(ssi_clk_o), .ssi_clk_oe(ssi_clk_oe), .ssi_data_i(ssi_data_i), .irq(irq)
    );
    ssi_encoder_model i_enc (.line_clk(line_clk), .word(word), .total(6'd14),
        .data(ssi_data_i));

    // Clock and hang guard
    initial forever #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            finish_test;
        end
    end

    // 12 data bits, then parity and stop; odd flips parity sense, bad breaks both
    function automatic logic [39:0] frm(input logic [11:0] d, input logic gray,
        input logic odd, input logic bad);
        logic [11:0] g;
        g = gray ? d ^ (d >> 1) : d;
        return {26'h0, g, ^g ^ odd ^ bad, bad};
    endfunction : frm

    task automatic finish_test;
        if (bad_count == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk

    // One APB transfer, request held until pready is sampled
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // No assumed latency: only the bench timeout ends a hung access
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask : rchk

    // Clear events, then wait for the next finished frame
    task automatic wait_frame;
        apb(1'b1, 8'h18, 32'h0000_0007);
        repeat (2) @(posedge sys_clk);
        // A frame that never comes runs into the bench timeout
        while (irq !== 1'b1) begin
            @(posedge sys_clk);
        end
    endtask : wait_frame

    initial begin
        repeat (8) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        rchk(8'h04, `SSI_CFG_RST);
        rchk(8'h00, 32'h0000_0000);
        apb(1'b0, 8'h22, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001);
        // Even parity then stop check; 12 bits, 2.5 MHz, 5 us, Gray
        apb(1'b1, 8'h08, 32'h0000_0006);
        apb(1'b1, 8'h04, 32'h0102_130C);
        rchk(8'h04, 32'h0102_130C);
        rchk(8'h08, 32'h0000_0006);
        apb(1'b1, 8'h1C, 32'h0000_0007);
        apb(1'b1, 8'h00, 32'h0000_0001);
        repeat (20) @(posedge sys_clk);
        chk({31'h0, ssi_clk_oe}, 32'h0000_0000);
        board_present <= 1'b1;
        val = 12'h3C5;
        // Good frame, then one with broken parity and stop
        for (int i = 0; i < 2; i++) begin
            word <= frm(val, 1'b1, 1'b0, i[0]);
            wait_frame;
            wait_frame;
            rchk(8'h0C, {20'h0, val});
            rchk(8'h10, {22'h0, i[0], i[0], 6'h0, word[1:0]});
            rchk(8'h14, {29'h0, i[0], i[0], 1'b1});
        end
        apb(1'b1, 8'h1C, 32'h0000_0000);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0000_0000);
        apb(1'b1, 8'h1C, 32'h0000_0007);
        wait_frame;
        // Switch to passive within the pause; odd parity, binary
        apb(1'b1, 8'h04, 32'h0101_000C);
        apb(1'b1, 8'h08, 32'h0000_0007);
        val = 12'hA5C;
        word <= frm(val, 1'b0, 1'b1, 1'b0);
        repeat (520) @(posedge sys_clk);
        chk({31'h0, ssi_clk_oe}, 32'h0000_0000);
        apb(1'b1, 8'h18, 32'h0000_0007);
        // Other master's clock, 320 ns period, only within the frame
        repeat (14) begin
            link_clk <= 1'b0;
            repeat (4) @(posedge sys_clk);
            link_clk <= 1'b1;
            repeat (4) @(posedge sys_clk);
        end
        repeat (10) @(posedge sys_clk);
        rchk(8'h0C, {20'h0, val});
        rchk(8'h10, {30'h0, word[1:0]});
        rchk(8'h14, 32'h0000_0001);
        // Back to active: 1.25 MHz, pause code 7 (50 cycles here, the shortest nonzero pause), binary, even parity
        val = 12'h5A3;
        word <= frm(val, 1'b0, 1'b0, 1'b0);
        apb(1'b1, 8'h08, 32'h0000_0006);
        apb(1'b1, 8'h04, 32'h0100_740C);
        wait_frame;
        wait_frame;
        rchk(8'h0C, {20'h0, val});
        rchk(8'h10, {30'h0, word[1:0]});
        finish_test;
    end
endmodule : ssi_encoder_receiver_tb_top
